// ---- core/ckd_pkg.sv ----
// Shared constants for the clock divider configuration block
`default_nettype none

package ckd_pkg;

    // ============================================================
    // Register bus geometry
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 8;

    // ============================================================
    // Register offsets
    localparam logic [7:0] PRIMARY_BIT_CLOCK_DIVIDER_LOW_ADDR   = 8'h3C;
    localparam logic [7:0] SECONDARY_BIT_CLOCK_DIVIDER_LOW_ADDR = 8'h3D;
    localparam logic [7:0] ANALOG_NM_DIVIDER_ADDR               = 8'h3E;
    localparam logic [7:0] CORE_DIVIDER_ENABLES_ADDR            = 8'h44;
    localparam logic [7:0] CONVERTER_PORT_DIVIDER_ENABLES_ADDR  = 8'h45;

    // ============================================================
    // Reset values
    localparam logic [7:0] PRIMARY_BIT_CLOCK_DIVIDER_LOW_RST   = 8'h01;
    localparam logic [7:0] SECONDARY_BIT_CLOCK_DIVIDER_LOW_RST = 8'h01;
    localparam logic [7:0] ANALOG_NM_DIVIDER_RST               = 8'h01;
    localparam logic [7:0] CORE_DIVIDER_ENABLES_RST            = 8'h00;
    localparam logic [7:0] CONVERTER_PORT_DIVIDER_ENABLES_RST  = 8'h00;
    localparam logic [7:0] UNMAPPED_READ_VALUE                 = 8'h00;

    // ============================================================
    // Writable-bit masks; reserved positions are cleared
    localparam logic [7:0] ANALOG_NM_DIVIDER_MASK    = 8'h3F;
    localparam logic [7:0] CORE_DIVIDER_ENABLES_MASK = 8'h07;

    // ============================================================
    // Field positions
    localparam int unsigned ANALOG_NM_RATIO_LSB             = 0;
    localparam int unsigned ANALOG_NM_RATIO_W               = 6;
    localparam int unsigned N_RATIO_ENABLE_BIT              = 2;
    localparam int unsigned M_RATIO_ENABLE_BIT              = 1;
    localparam int unsigned PULSE_DENSITY_RATIO_ENABLE_BIT  = 0;
    localparam int unsigned INPUT_CONV_MATCHING_ENABLE_BIT  = 7;
    localparam int unsigned INPUT_CONV_MODULATOR_ENABLE_BIT = 6;
    localparam int unsigned OUTPUT_CONV_MATCHING_ENABLE_BIT = 5;
    localparam int unsigned OUTPUT_CONV_MODULATOR_ENABLE_BIT = 4;
    localparam int unsigned PRIMARY_BITCLK_RATIO_ENABLE_BIT = 3;
    localparam int unsigned SECONDARY_BITCLK_RATIO_ENABLE_BIT = 2;
    localparam int unsigned PRIMARY_FRAME_RATIO_ENABLE_BIT  = 1;
    localparam int unsigned SECONDARY_FRAME_RATIO_ENABLE_BIT = 0;

    // ============================================================
    // Divider code widths; code zero means two to the width
    localparam int unsigned BITCLK_CODE_W = 9;
    localparam int unsigned N_CODE_W      = 3;
    localparam int unsigned M_CODE_W      = 6;

endpackage

`default_nettype wire

// ---- core/ckd_divider.sv ----
// Programmable tick divider where code zero selects two to the code width
`default_nettype none

module ckd_divider
    import ckd_pkg::*;
#(
    parameter int unsigned CODE_W = 6
)
(
    input  wire logic              clock,
    input  wire logic              rst_b,
    input  wire logic              enable,
    input  wire logic              src_tick,
    input  wire logic [CODE_W-1:0] code,
    output logic                   div_clk,
    output logic                   div_pulse
);

    // ============================================================
    // Ratio decode: zero wraps to full range, others divide by themselves
    logic [CODE_W:0] ratio;
    logic [CODE_W:0] high_len;

    always_comb
    begin
        if (code == '0)
        begin
            ratio = {1'b1, {CODE_W{1'b0}}};
        end
        else
        begin
            ratio = {1'b0, code};
        end
        // High phase takes the larger half, so ratio one stays high
        high_len = ratio - (ratio >> 1);
    end

    // ============================================================
    // Counter and outputs
    logic [CODE_W:0] cnt_reg;
    logic [CODE_W:0] cnt_next;
    logic            clk_reg;
    logic            clk_next;
    logic            pulse_reg;
    logic            pulse_next;

    // A code shrunk below the count wraps at once instead of running away
    always_comb
    begin
        cnt_next   = cnt_reg;
        clk_next   = clk_reg;
        pulse_next = 1'b0;
        if (!enable)
        begin
            cnt_next = '0;
            clk_next = 1'b0;
        end
        else if (src_tick)
        begin
            if (cnt_reg >= ratio - 1'b1)
            begin
                cnt_next   = '0;
                pulse_next = 1'b1;
            end
            else
            begin
                cnt_next = cnt_reg + 1'b1;
            end
            clk_next = (cnt_next < high_len);
        end
    end

    // Registered so the divided clock is glitch free
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cnt_reg   <= '0;
            clk_reg   <= 1'b0;
            pulse_reg <= 1'b0;
        end
        else
        begin
            cnt_reg   <= cnt_next;
            clk_reg   <= clk_next;
            pulse_reg <= pulse_next;
        end
    end

    assign div_clk   = clk_reg;
    assign div_pulse = pulse_reg;

endmodule

`default_nettype wire

// ---- core/ckd_core.sv ----
// Clock divider configuration registers and the dividers they steer
//
// Behaviour
// - Bit-clock code zero divides by 512.
// - Bit-clock codes one and two divide exactly.
// - Codes three to sixty-two divide by code.
// - Largest bit-clock code divides by 511.
// - Two bit-clock low bytes, reset one.
// - Auto detection overrides all programmed divider codes.
// - Analog ratio six bits, zero means 64.
// - Bits two, one enable N, M.
// - Bit zero enables pulse-density divider.
// - Bits seven, six enable input converter dividers.
// - Bits five, four enable output converter dividers.
// - Bits three, two enable bit-clock dividers.
// - Bits one, zero enable frame dividers.
// - High bit extends each bit-clock code.
// - N code zero divides by eight.
// - M code zero divides by 64.
`default_nettype none

module ckd_core
    import ckd_pkg::*;
(
    input  wire logic                 clock,
    input  wire logic                 rst_b,
    // Register port
    input  wire logic [ADDR_W-1:0]    reg_addr,
    input  wire logic                 reg_wr_en,
    input  wire logic [DATA_W-1:0]    reg_wr_data,
    input  wire logic                 reg_rd_en,
    output logic      [DATA_W-1:0]    reg_rd_data,
    // Neighbouring configuration bits
    input  wire logic                 primary_bitclk_ratio_high,
    input  wire logic                 secondary_bitclk_ratio_high,
    input  wire logic [N_CODE_W-1:0]  n_ratio,
    input  wire logic [M_CODE_W-1:0]  m_ratio,
    // Automatic clock detection
    input  wire logic                 auto_detect_active,
    input  wire logic [BITCLK_CODE_W-1:0] auto_primary_bitclk_code,
    input  wire logic [BITCLK_CODE_W-1:0] auto_secondary_bitclk_code,
    input  wire logic [ANALOG_NM_RATIO_W-1:0] auto_analog_nm_code,
    input  wire logic [N_CODE_W-1:0]  auto_n_code,
    input  wire logic [M_CODE_W-1:0]  auto_m_code,
    // Source ticks
    input  wire logic                 audio_src_tick,
    input  wire logic                 pll_src_tick,
    // Divided clocks and wrap pulses
    output logic                      primary_bitclk_out,
    output logic                      primary_bitclk_pulse,
    output logic                      secondary_bitclk_out,
    output logic                      secondary_bitclk_pulse,
    output logic                      analog_nm_out,
    output logic                      analog_nm_pulse,
    output logic                      n_out,
    output logic                      n_pulse,
    output logic                      m_out,
    output logic                      m_pulse,
    // Enables for dividers outside this block
    output logic                      pulse_density_ratio_enable,
    output logic                      input_conv_matching_enable,
    output logic                      input_conv_modulator_enable,
    output logic                      output_conv_matching_enable,
    output logic                      output_conv_modulator_enable,
    output logic                      primary_frame_ratio_enable,
    output logic                      secondary_frame_ratio_enable
);

    // ============================================================
    // Configuration registers
    logic [DATA_W-1:0] primary_bit_clock_divider_low_reg;
    logic [DATA_W-1:0] primary_bit_clock_divider_low_next;
    logic [DATA_W-1:0] secondary_bit_clock_divider_low_reg;
    logic [DATA_W-1:0] secondary_bit_clock_divider_low_next;
    logic [DATA_W-1:0] analog_nm_divider_reg;
    logic [DATA_W-1:0] analog_nm_divider_next;
    logic [DATA_W-1:0] core_divider_enables_reg;
    logic [DATA_W-1:0] core_divider_enables_next;
    logic [DATA_W-1:0] converter_port_divider_enables_reg;
    logic [DATA_W-1:0] converter_port_divider_enables_next;
    logic [DATA_W-1:0] rd_data_reg;
    logic [DATA_W-1:0] rd_data_next;

    // Write decode; reserved positions are masked so they never store
    always_comb
    begin
        primary_bit_clock_divider_low_next   = primary_bit_clock_divider_low_reg;
        secondary_bit_clock_divider_low_next = secondary_bit_clock_divider_low_reg;
        analog_nm_divider_next               = analog_nm_divider_reg;
        core_divider_enables_next            = core_divider_enables_reg;
        converter_port_divider_enables_next  = converter_port_divider_enables_reg;
        if (reg_wr_en)
        begin
            unique case (reg_addr)
                PRIMARY_BIT_CLOCK_DIVIDER_LOW_ADDR:
                    primary_bit_clock_divider_low_next = reg_wr_data;
                SECONDARY_BIT_CLOCK_DIVIDER_LOW_ADDR:
                    secondary_bit_clock_divider_low_next = reg_wr_data;
                ANALOG_NM_DIVIDER_ADDR:
                    analog_nm_divider_next = reg_wr_data & ANALOG_NM_DIVIDER_MASK;
                CORE_DIVIDER_ENABLES_ADDR:
                    core_divider_enables_next =
                        reg_wr_data & CORE_DIVIDER_ENABLES_MASK;
                CONVERTER_PORT_DIVIDER_ENABLES_ADDR:
                    converter_port_divider_enables_next = reg_wr_data;
                default:
                    primary_bit_clock_divider_low_next =
                        primary_bit_clock_divider_low_reg;                // Unmapped writes drop
            endcase
        end
    end

    // Read mux, registered so read data is glitch free
    always_comb
    begin
        rd_data_next = rd_data_reg;
        if (reg_rd_en)
        begin
            unique case (reg_addr)
                PRIMARY_BIT_CLOCK_DIVIDER_LOW_ADDR:
                    rd_data_next = primary_bit_clock_divider_low_reg;
                SECONDARY_BIT_CLOCK_DIVIDER_LOW_ADDR:
                    rd_data_next = secondary_bit_clock_divider_low_reg;
                ANALOG_NM_DIVIDER_ADDR:
                    rd_data_next = analog_nm_divider_reg;
                CORE_DIVIDER_ENABLES_ADDR:
                    rd_data_next = core_divider_enables_reg;
                CONVERTER_PORT_DIVIDER_ENABLES_ADDR:
                    rd_data_next = converter_port_divider_enables_reg;
                default:
                    rd_data_next = UNMAPPED_READ_VALUE;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            primary_bit_clock_divider_low_reg   <= PRIMARY_BIT_CLOCK_DIVIDER_LOW_RST;
            secondary_bit_clock_divider_low_reg <= SECONDARY_BIT_CLOCK_DIVIDER_LOW_RST;
            analog_nm_divider_reg               <= ANALOG_NM_DIVIDER_RST;
            core_divider_enables_reg            <= CORE_DIVIDER_ENABLES_RST;
            converter_port_divider_enables_reg  <= CONVERTER_PORT_DIVIDER_ENABLES_RST;
            rd_data_reg                         <= UNMAPPED_READ_VALUE;
        end
        else
        begin
            primary_bit_clock_divider_low_reg   <= primary_bit_clock_divider_low_next;
            secondary_bit_clock_divider_low_reg <= secondary_bit_clock_divider_low_next;
            analog_nm_divider_reg               <= analog_nm_divider_next;
            core_divider_enables_reg            <= core_divider_enables_next;
            converter_port_divider_enables_reg  <= converter_port_divider_enables_next;
            rd_data_reg                         <= rd_data_next;
        end
    end

    assign reg_rd_data = rd_data_reg;

    // ============================================================
    // Effective divider codes
    // Programmed codes are ignored outright while detection runs, so a
    // half-written setup never reaches the dividers during a rate change.
    logic [BITCLK_CODE_W-1:0]     primary_bitclk_code;
    logic [BITCLK_CODE_W-1:0]     secondary_bitclk_code;
    logic [ANALOG_NM_RATIO_W-1:0] analog_nm_ratio;
    logic [N_CODE_W-1:0]          n_code;
    logic [M_CODE_W-1:0]          m_code;

    always_comb
    begin
        if (auto_detect_active)
        begin
            primary_bitclk_code   = auto_primary_bitclk_code;
            secondary_bitclk_code = auto_secondary_bitclk_code;
            analog_nm_ratio       = auto_analog_nm_code;
            n_code                = auto_n_code;
            m_code                = auto_m_code;
        end
        else
        begin
            primary_bitclk_code   = {primary_bitclk_ratio_high,
                                     primary_bit_clock_divider_low_reg};
            secondary_bitclk_code = {secondary_bitclk_ratio_high,
                                     secondary_bit_clock_divider_low_reg};
            analog_nm_ratio       = analog_nm_divider_reg[ANALOG_NM_RATIO_LSB +:
                                                          ANALOG_NM_RATIO_W];
            n_code                = n_ratio;
            m_code                = m_ratio;
        end
    end

    // ============================================================
    // Enable bits
    logic n_ratio_enable;
    logic m_ratio_enable;
    logic primary_bitclk_ratio_enable;
    logic secondary_bitclk_ratio_enable;

    assign n_ratio_enable = core_divider_enables_reg[N_RATIO_ENABLE_BIT];
    assign m_ratio_enable = core_divider_enables_reg[M_RATIO_ENABLE_BIT];
    assign pulse_density_ratio_enable =
        core_divider_enables_reg[PULSE_DENSITY_RATIO_ENABLE_BIT];
    assign input_conv_matching_enable =
        converter_port_divider_enables_reg[INPUT_CONV_MATCHING_ENABLE_BIT];
    assign input_conv_modulator_enable =
        converter_port_divider_enables_reg[INPUT_CONV_MODULATOR_ENABLE_BIT];
    assign output_conv_matching_enable =
        converter_port_divider_enables_reg[OUTPUT_CONV_MATCHING_ENABLE_BIT];
    assign output_conv_modulator_enable =
        converter_port_divider_enables_reg[OUTPUT_CONV_MODULATOR_ENABLE_BIT];
    assign primary_bitclk_ratio_enable =
        converter_port_divider_enables_reg[PRIMARY_BITCLK_RATIO_ENABLE_BIT];
    assign secondary_bitclk_ratio_enable =
        converter_port_divider_enables_reg[SECONDARY_BITCLK_RATIO_ENABLE_BIT];
    assign primary_frame_ratio_enable =
        converter_port_divider_enables_reg[PRIMARY_FRAME_RATIO_ENABLE_BIT];
    assign secondary_frame_ratio_enable =
        converter_port_divider_enables_reg[SECONDARY_FRAME_RATIO_ENABLE_BIT];

    // ============================================================
    // Dividers; each clears its count and idles low when disabled
    // Bit-clock ratio: 0 gives 512, others themselves
    ckd_divider #(.CODE_W(BITCLK_CODE_W)) primary_bitclk_div
    (
        .clock     (clock),
        .rst_b     (rst_b),
        .enable    (primary_bitclk_ratio_enable),
        .src_tick  (audio_src_tick),
        .code      (primary_bitclk_code),
        .div_clk   (primary_bitclk_out),
        .div_pulse (primary_bitclk_pulse)
    );

    // Same decode for the secondary port
    ckd_divider #(.CODE_W(BITCLK_CODE_W)) secondary_bitclk_div
    (
        .clock     (clock),
        .rst_b     (rst_b),
        .enable    (secondary_bitclk_ratio_enable),
        .src_tick  (audio_src_tick),
        .code      (secondary_bitclk_code),
        .div_clk   (secondary_bitclk_out),
        .div_pulse (secondary_bitclk_pulse)
    );

    // Analog ratio has no enable of its own here, so it always runs
    ckd_divider #(.CODE_W(ANALOG_NM_RATIO_W)) analog_nm_div
    (
        .clock     (clock),
        .rst_b     (rst_b),
        .enable    (1'b1),
        .src_tick  (audio_src_tick),
        .code      (analog_nm_ratio),
        .div_clk   (analog_nm_out),
        .div_pulse (analog_nm_pulse)
    );

    // N ratio: code 0 gives 8
    ckd_divider #(.CODE_W(N_CODE_W)) n_div
    (
        .clock     (clock),
        .rst_b     (rst_b),
        .enable    (n_ratio_enable),
        .src_tick  (pll_src_tick),
        .code      (n_code),
        .div_clk   (n_out),
        .div_pulse (n_pulse)
    );

    // M ratio: code 0 gives 64
    ckd_divider #(.CODE_W(M_CODE_W)) m_div
    (
        .clock     (clock),
        .rst_b     (rst_b),
        .enable    (m_ratio_enable),
        .src_tick  (pll_src_tick),
        .code      (m_code),
        .div_clk   (m_out),
        .div_pulse (m_pulse)
    );

endmodule

`default_nettype wire

// ---- verification/ckd_core_props.sv ----
// Assertion checker for the clock divider configuration block
`default_nettype none

module ckd_core_props
    import ckd_pkg::*;
(
    input wire logic              clock,
    input wire logic              rst_b,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic              reg_wr_en,
    input wire logic [DATA_W-1:0] reg_wr_data,
    input wire logic              reg_rd_en,
    input wire logic [DATA_W-1:0] reg_rd_data,
    input wire logic              n_out,
    input wire logic              n_pulse,
    input wire logic              m_out,
    input wire logic              m_pulse,
    input wire logic              input_conv_matching_enable,
    input wire logic              input_conv_modulator_enable,
    input wire logic              output_conv_matching_enable,
    input wire logic              output_conv_modulator_enable,
    input wire logic              primary_frame_ratio_enable,
    input wire logic              secondary_frame_ratio_enable,
    input wire logic              pulse_density_ratio_enable
);
    // ============================================================
    // Helpers
    logic [5:0] port_en;
    logic       port_wr;
    logic       core_wr;
    assign port_en = {input_conv_matching_enable, input_conv_modulator_enable,
                      output_conv_matching_enable, output_conv_modulator_enable,
                      primary_frame_ratio_enable, secondary_frame_ratio_enable};
    assign port_wr = reg_wr_en && reg_addr == CONVERTER_PORT_DIVIDER_ENABLES_ADDR;
    assign core_wr = reg_wr_en && reg_addr == CORE_DIVIDER_ENABLES_ADDR;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);

    // ============================================================
    // Register port
    AST_UNMAPPED_READ_ZERO: assert property (
        reg_rd_en && !(reg_addr inside {8'h3C, 8'h3D, 8'h3E, 8'h44, 8'h45})
        |=> reg_rd_data == UNMAPPED_READ_VALUE) else $error("unmapped read not zero");
    AST_NM_RESERVED_ZERO: assert property (
        reg_rd_en && reg_addr == ANALOG_NM_DIVIDER_ADDR |=> reg_rd_data[7:6] == 2'h0)
        else $error("analog ratio reserved bits not zero");
    AST_CORE_RESERVED_ZERO: assert property (
        reg_rd_en && reg_addr == CORE_DIVIDER_ENABLES_ADDR |=> reg_rd_data[7:3] == 5'h00)
        else $error("core enable reserved bits not zero");
    AST_PORT_ENABLES_FOLLOW_WRITE: assert property (
        port_wr |=> {port_en[5:2], 2'h0, port_en[1:0]} == ($past(reg_wr_data) & 8'hF3))
        else $error("port enables differ from written byte");
    AST_PULSE_DENSITY_FOLLOWS_WRITE: assert property (
        core_wr |=> {7'h00, pulse_density_ratio_enable} == ($past(reg_wr_data) & 8'h01))
        else $error("pulse density enable differs from written bit");
    AST_PORT_ENABLES_HOLD: assert property (
        !port_wr |=> $stable(port_en)) else $error("port enables changed without a write");

    // Disabled dividers must fall quiet one cycle after the register updates
    AST_N_DISABLED_QUIET: assert property (
        core_wr && !reg_wr_data[N_RATIO_ENABLE_BIT] ##1 !core_wr
        |=> (!n_out && !n_pulse) [*2])
        else $error("N divider active while disabled");
    AST_M_DISABLED_QUIET: assert property (
        core_wr && !reg_wr_data[M_RATIO_ENABLE_BIT] ##1 !core_wr
        |=> (!m_out && !m_pulse) [*2])
        else $error("M divider active while disabled");

    COV_PORT_WRITE: cover property (port_wr);
    COV_N_WRAP: cover property (n_pulse);
    COV_M_WRAP: cover property (m_pulse);
endmodule

bind ckd_core ckd_core_props u_props (.clock(clock), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en),
    .reg_rd_data(reg_rd_data), .n_out(n_out), .n_pulse(n_pulse), .m_out(m_out),
    .m_pulse(m_pulse), .input_conv_matching_enable(input_conv_matching_enable),
    .input_conv_modulator_enable(input_conv_modulator_enable),
    .output_conv_matching_enable(output_conv_matching_enable),
    .output_conv_modulator_enable(output_conv_modulator_enable),
    .primary_frame_ratio_enable(primary_frame_ratio_enable),
    .secondary_frame_ratio_enable(secondary_frame_ratio_enable),
    .pulse_density_ratio_enable(pulse_density_ratio_enable));

`default_nettype wire

// ---- verification/testbench.sv ----
// Self-checking testbench for the clock divider configuration block
`default_nettype none

module testbench
    import ckd_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    // ============================================================
    // Stimulus tables: mapped places plus one unmapped address
    localparam logic [7:0] ADDRS [6] = '{8'h3C, 8'h3D, 8'h3E, 8'h44, 8'h45, 8'h50};
    localparam logic [7:0] RSTS  [6] = '{8'h01, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00};
    localparam logic [7:0] MASKS [6] = '{8'hFF, 8'hFF, 8'h3F, 8'h07, 8'hFF, 8'h00};
    localparam logic [8:0] CODES [6] = '{9'h001, 9'h002, 9'h003, 9'h03E, 9'h000, 9'h1FF};

    logic       clock = 1'b0;
    logic       rst_b = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wr_data = 8'h00;
    logic       reg_wr_en = 1'b0, reg_rd_en = 1'b0, auto_detect_active = 1'b0;
    logic       p_high = 1'b0, s_high = 1'b0, audio_tick = 1'b0, pll_tick = 1'b0;
    logic [2:0] n_ratio = 3'h1, auto_n = 3'h1;
    logic [5:0] m_ratio = 6'h01, auto_m = 6'h01, auto_nm = 6'h01;
    logic [8:0] auto_p = 9'h001, auto_s = 9'h001;
    wire  [7:0] reg_rd_data;
    wire  [4:0] outs, pulses;
    wire  [6:0] ens;
    int         n_mismatch = 0, checks = 0;

    ckd_core DUT (.clock(clock), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
        .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data),
        .primary_bitclk_ratio_high(p_high), .secondary_bitclk_ratio_high(s_high),
        .n_ratio(n_ratio), .m_ratio(m_ratio), .auto_detect_active(auto_detect_active),
        .auto_primary_bitclk_code(auto_p), .auto_secondary_bitclk_code(auto_s),
        .auto_analog_nm_code(auto_nm), .auto_n_code(auto_n), .auto_m_code(auto_m),
        .audio_src_tick(audio_tick), .pll_src_tick(pll_tick),
        .primary_bitclk_out(outs[0]), .primary_bitclk_pulse(pulses[0]),
        .secondary_bitclk_out(outs[1]), .secondary_bitclk_pulse(pulses[1]),
        .analog_nm_out(outs[2]), .analog_nm_pulse(pulses[2]), .n_out(outs[3]),
        .n_pulse(pulses[3]), .m_out(outs[4]), .m_pulse(pulses[4]),
        .pulse_density_ratio_enable(ens[6]), .input_conv_matching_enable(ens[5]),
        .input_conv_modulator_enable(ens[4]), .output_conv_matching_enable(ens[3]),
        .output_conv_modulator_enable(ens[2]), .primary_frame_ratio_enable(ens[1]),
        .secondary_frame_ratio_enable(ens[0]));

    // 200 MHz clock
    always #2.5 clock = ~clock;

    // ============================================================
    // Tasks
    task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("unexpected %s: expected %0h, seen %0h", what, exp, seen);
        end
    endtask

    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wr_data <= d;
        reg_wr_en <= 1'b1;
        @(posedge clock);
        reg_wr_en <= 1'b0;
    endtask

    // Read data lands one cycle after the strobe is taken
    task rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clock);
        reg_addr <= a;
        reg_rd_en <= 1'b1;
        @(posedge clock);
        reg_rd_en <= 1'b0;
        #1;
        check("read data", {8'h00, reg_rd_data}, {8'h00, exp});
    endtask

    // Ticks come every cycle, so the gap between two wraps is the ratio
    task measure(input int idx, input int ratio);
        int t;
        t = 0;
        repeat (3) @(posedge clock);
        #1;
        while (pulses[idx] !== 1'b1 && t < 1100)
        begin
            @(posedge clock);
            #1;
            t++;
        end
        t = 0;
        do
        begin
            @(posedge clock);
            #1;
            t++;
        end while (pulses[idx] !== 1'b1 && t < 1100);
        check("divider period", 16'(t), 16'(ratio));
        check("divider clock at wrap", {15'h0, outs[idx]}, 16'h0001);
    endtask

    task finish_test;
        $display("mismatches %0d, checks %0d", n_mismatch, checks);
        if (n_mismatch == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // ============================================================
    // Main sequence
    initial
    begin
        int         i;
        logic [7:0] d;
        repeat (5) @(posedge clock);
        rst_b <= 1'b1;
        audio_tick <= 1'b1;
        pll_tick <= 1'b1;
        for (i = 0; i < 6; i++) rd(ADDRS[i], RSTS[i]);
        // Reserved bits only ever get their reset value from software
        for (i = 0; i < 6; i++) wr(ADDRS[i], i == 5 ? 8'hFF : MASKS[i]);
        for (i = 0; i < 6; i++) rd(ADDRS[i], MASKS[i]);
        check("enables", {9'h000, ens}, 16'h007F);
        // Walk a single one across the port enable byte
        for (i = 0; i < 8; i++)
        begin
            d = 8'h01 << i;
            wr(CONVERTER_PORT_DIVIDER_ENABLES_ADDR, d);
            #1;
            check("port enables", {10'h000, ens[5:0]},
                  {10'h000, d[7:4], d[1:0]});
        end
        wr(CORE_DIVIDER_ENABLES_ADDR, 8'h06);
        wr(CONVERTER_PORT_DIVIDER_ENABLES_ADDR, 8'h0C);
        for (i = 0; i < 6; i++)
        begin
            @(posedge clock);
            p_high <= CODES[i][8];
            wr(PRIMARY_BIT_CLOCK_DIVIDER_LOW_ADDR, CODES[i][7:0]);
            measure(0, CODES[i] == 9'h000 ? 512 : int'(CODES[i]));
        end
        @(posedge clock);
        s_high <= 1'b1;
        wr(SECONDARY_BIT_CLOCK_DIVIDER_LOW_ADDR, 8'h00);
        measure(1, 256);
        @(posedge clock);
        s_high <= 1'b0;
        wr(SECONDARY_BIT_CLOCK_DIVIDER_LOW_ADDR, 8'h05);
        measure(1, 5);
        wr(ANALOG_NM_DIVIDER_ADDR, 8'h00);
        measure(2, 64);
        wr(ANALOG_NM_DIVIDER_ADDR, 8'h07);
        measure(2, 7);
        @(posedge clock);
        n_ratio <= 3'h0;
        m_ratio <= 6'h00;
        measure(3, 8);
        measure(4, 64);
        // Automatic detection overrides programmed codes; primary bit-clock, N and analog are measured
        @(posedge clock);
        auto_detect_active <= 1'b1;
        auto_p <= 9'h006;
        auto_n <= 3'h5;
        auto_nm <= 6'h09;
        measure(0, 6);
        measure(3, 5);
        measure(2, 9);
        @(posedge clock);
        auto_detect_active <= 1'b0;
        wr(CORE_DIVIDER_ENABLES_ADDR, 8'h00);
        wr(CONVERTER_PORT_DIVIDER_ENABLES_ADDR, 8'h00);
        repeat (3) @(posedge clock);
        #1;
        check("disabled outputs",
              {12'h000, outs[4:3], outs[1:0]} | {pulses[4:3], pulses[1:0]}, 16'h0000);
        finish_test();
    end

    // Watchdog well beyond the expected run of about 3000 cycles
    initial
    begin
        #300000;
        n_mismatch++;
        finish_test();
    end
endmodule

`default_nettype wire
